// [clp_current_loop.sv]
// current loop inputs with alarm/trip stages and current loop outputs
`timescale 1ns/1ns
// Overview of operation
// - each input selects 0-1, 0-10, 0-20 or 4-20 mA span.
// - a disabled input never asserts its alarm or trip stage.
// - alarm and trip pick up when scaled value exceeds their threshold.
// - thresholds stay within min..max; each stage waits its own delay.
// - input current maps linearly, range low end to min, top to max.
// - min above max gives an inverted, falling mapping.
// - min and max are limited by the span of the selected unit.
// - each input's scaled value is readable as its own measurement.
// - four outputs, each selecting 0-1, 0-10, 0-20 or 4-20 mA.
// - each output is assigned one selected internal measurement.
// - output maps its measurement window linearly onto the current span.
// - voltage, current and power sources are primary-side quantities.
// - on 4-20 mA, a value at the minimum still drives nonzero current.
module clp_current_loop
    import clp_pkg::*;
#(
    parameter int TICK_CYCLES = MS_TICK_CYC
)
(
    input  wire logic                    clk_sys,
    input  wire logic                    resetn,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    input  wire logic [NUM_CH-1:0][15:0] loopCurUa,
    input  wire logic [NUM_CH-1:0]       loopValid,
    input  wire logic [NUM_SRC-1:0][31:0] measPrimary,
    output logic [NUM_CH-1:0][15:0]      loopOutUa,
    output logic [NUM_CH-1:0]            alarmOut,
    output logic [NUM_CH-1:0]            tripOut
);

    typedef struct packed {
        logic [NUM_CH-1:0]        inEn;
        logic [NUM_CH-1:0][1:0]   inRng;
        logic [NUM_CH-1:0][3:0]   inUnit;
        logic [NUM_CH-1:0][31:0]  inMin;
        logic [NUM_CH-1:0][31:0]  inMax;
        logic [NUM_CH-1:0][31:0]  almThr;
        logic [NUM_CH-1:0][31:0]  trpThr;
        logic [NUM_CH-1:0][31:0]  meas;
        logic [NUM_CH-1:0][15:0]  almDly;
        logic [NUM_CH-1:0][15:0]  trpDly;
        logic [NUM_CH-1:0][1:0]   outRng;
        logic [NUM_CH-1:0][3:0]   outSel;
        logic [NUM_CH-1:0][31:0]  outMin;
        logic [NUM_CH-1:0][31:0]  outMax;
        logic [NUM_CH-1:0][15:0]  outUa;
        logic [31:0]              tickCnt;
        logic                     tick;
        logic                     dpWr;
        logic                     dpMapped;
        logic [7:0]               dpAddr;
        logic [31:0]              rdata;
    } clp_top_state_t;

    clp_top_state_t q;
    clp_top_state_t n;
    logic [1:0]     wrCh;

    function automatic logic signed [63:0] sx64(input logic [31:0] v);
        return 64'($signed(v));
    endfunction

    // bounds may come in either order, so an inverted min/max still works
    function automatic logic [31:0] clampS(input logic [31:0] v,
                                           input logic [31:0] a,
                                           input logic [31:0] b);
        logic signed [31:0] lo;
        logic signed [31:0] hi;
        lo = ($signed(a) < $signed(b)) ? $signed(a) : $signed(b);
        hi = ($signed(a) < $signed(b)) ? $signed(b) : $signed(a);
        if ($signed(v) < lo) begin
            return lo;
        end
        if ($signed(v) > hi) begin
            return hi;
        end
        return v;
    endfunction

    function automatic logic [31:0] scaleIn(input logic [15:0] cur,
                                            input logic [1:0]  rng,
                                            input logic [31:0] mn,
                                            input logic [31:0] mx);
        logic [15:0]        lo;
        logic [15:0]        hi;
        logic [15:0]        c;
        logic signed [63:0] d;
        logic signed [63:0] den;
        logic signed [63:0] r;
        lo  = RANGE_LO_UA[rng];
        hi  = RANGE_HI_UA[rng];
        c   = (cur < lo) ? lo : ((cur > hi) ? hi : cur);
        d   = {48'h0000_0000_0000, 16'(c - lo)};
        den = {48'h0000_0000_0000, 16'(hi - lo)};
        // signed span keeps the slope negative when min > max
        r   = sx64(mn)
              + (d * (sx64(mx) - sx64(mn))) / den;
        return 32'(r);
    endfunction

    function automatic logic [15:0] scaleOut(input logic [31:0] m,
                                             input logic [1:0]  rng,
                                             input logic [31:0] mn,
                                             input logic [31:0] mx);
        logic signed [63:0] lo;
        logic signed [63:0] hi;
        logic signed [63:0] den;
        logic signed [63:0] v;
        lo  = {48'h0000_0000_0000, RANGE_LO_UA[rng]};
        hi  = {48'h0000_0000_0000, RANGE_HI_UA[rng]};
        den = sx64(mx) - sx64(mn);
        if (den == 64'sh0) begin
            v = lo;
        end else begin
            v = lo + ((sx64(m) - sx64(mn)) * (hi - lo)) / den;
        end
        if (v < lo) begin
            v = lo;
        end
        if (v > hi) begin
            v = hi;
        end
        return 16'(v);
    endfunction

    function automatic logic [31:0] regRead(input clp_top_state_t s,
                                            input logic [31:0] a,
                                            input logic [7:0] st);
        logic [31:0] r;
        logic [1:0]  c;
        r = RST_WORD;
        c = 2'h0;
        if (a[31:8] != 24'h00_0000) begin
            return r;
        end
        if (!a[7]) begin
            c = a[6:5];
            unique case (a[4:2])
                OFS_IN_CFG: begin
                    r[CFG_EN_BIT]        = s.inEn[c];
                    r[CFG_RNG_LSB+:2]    = s.inRng[c];
                    r[CFG_UNIT_LSB+:4]   = s.inUnit[c];
                end
                OFS_IN_MIN:  r = s.inMin[c];
                OFS_IN_MAX:  r = s.inMax[c];
                OFS_ALM_THR: r = s.almThr[c];
                OFS_ALM_DLY: r = {16'h0000, s.almDly[c]};
                OFS_TRP_THR: r = s.trpThr[c];
                OFS_TRP_DLY: r = {16'h0000, s.trpDly[c]};
                OFS_IN_MEAS: r = s.meas[c];
            endcase
        end else if (a[7:6] == OUT_BASE[7:6]) begin
            c = a[5:4];
            unique case (a[3:2])
                OFS_OUT_CFG: begin
                    r[OCFG_RNG_LSB+:2] = s.outRng[c];
                    r[OCFG_SEL_LSB+:4] = s.outSel[c];
                end
                OFS_OUT_MIN: r = s.outMin[c];
                OFS_OUT_MAX: r = s.outMax[c];
                OFS_OUT_UA:  r = {16'h0000, s.outUa[c]};
            endcase
        end else if (a[7:0] == STATUS_ADDR) begin
            r = {24'h00_0000, st};
        end
        return r;
    endfunction

    always_comb begin
        n      = q;
        wrCh   = 2'h0;
        n.tick = 1'b0;
        if (q.tickCnt >= 32'(TICK_CYCLES - 1)) begin
            n.tickCnt = '0;
            n.tick    = 1'b1;
        end else begin
            n.tickCnt = q.tickCnt + 32'h0000_0001;
        end

        // data phase of a write taken in the previous cycle
        if (q.dpWr && q.dpMapped) begin
            if (!q.dpAddr[7]) begin
                wrCh = q.dpAddr[6:5];
                unique case (q.dpAddr[4:2])
                    OFS_IN_CFG: begin
                        n.inEn[wrCh]   = hwdata[CFG_EN_BIT];
                        n.inRng[wrCh]  = hwdata[CFG_RNG_LSB+:2];
                        n.inUnit[wrCh] = hwdata[CFG_UNIT_LSB+:4];
                    end
                    OFS_IN_MIN:  n.inMin[wrCh]  = hwdata;
                    OFS_IN_MAX:  n.inMax[wrCh]  = hwdata;
                    OFS_ALM_THR: n.almThr[wrCh] = hwdata;
                    OFS_ALM_DLY: n.almDly[wrCh] = hwdata[15:0];
                    OFS_TRP_THR: n.trpThr[wrCh] = hwdata;
                    OFS_TRP_DLY: n.trpDly[wrCh] = hwdata[15:0];
                    OFS_IN_MEAS: ;
                endcase
            end else if (q.dpAddr[7:6] == OUT_BASE[7:6]) begin
                wrCh = q.dpAddr[5:4];
                unique case (q.dpAddr[3:2])
                    OFS_OUT_CFG: begin
                        n.outRng[wrCh] = hwdata[OCFG_RNG_LSB+:2];
                        n.outSel[wrCh] = hwdata[OCFG_SEL_LSB+:4];
                    end
                    OFS_OUT_MIN: n.outMin[wrCh] = hwdata;
                    OFS_OUT_MAX: n.outMax[wrCh] = hwdata;
                    OFS_OUT_UA:  ;
                endcase
            end
        end

        // limits re-applied every cycle, so a unit or window change
        // immediately pulls dependent settings back into range
        for (int i = 0; i < NUM_CH; i++) begin
            n.inMin[i]  = clampS(n.inMin[i], UNIT_LO[n.inUnit[i]],
                                 UNIT_HI[n.inUnit[i]]);
            n.inMax[i]  = clampS(n.inMax[i], UNIT_LO[n.inUnit[i]],
                                 UNIT_HI[n.inUnit[i]]);
            n.almThr[i] = clampS(n.almThr[i], n.inMin[i],
                                 n.inMax[i]);
            n.trpThr[i] = clampS(n.trpThr[i], n.inMin[i],
                                 n.inMax[i]);
            if (loopValid[i]) begin
                n.meas[i] = scaleIn(loopCurUa[i], q.inRng[i], q.inMin[i],
                                    q.inMax[i]);
            end
            // sources arrive already scaled to primary side
            n.outUa[i] = scaleOut(measPrimary[q.outSel[i]], q.outRng[i],
                                  q.outMin[i], q.outMax[i]);
        end

        // address phase; reads see this cycle's write (no stale readback)
        n.dpWr     = 1'b0;
        n.dpMapped = 1'b0;
        if (hsel && hready && htrans[1]) begin
            n.dpWr     = hwrite;
            n.dpAddr   = haddr[7:0];
            n.dpMapped = (haddr[31:8] == 24'h00_0000);
            if (!hwrite) begin
                n.rdata = regRead(n, haddr, {tripOut, alarmOut});
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;
    assign hrdata    = q.rdata;
    assign loopOutUa = q.outUa;

    clp_stage_if sIf [2*NUM_CH] ();

    for (genvar g = 0; g < NUM_CH; g++) begin : gStage
        assign sIf[g].en             = q.inEn[g];
        assign sIf[g].value          = $signed(q.meas[g]);
        assign sIf[g].thr            = $signed(q.almThr[g]);
        assign sIf[g].dly            = q.almDly[g];
        assign sIf[g].tick           = q.tick;
        assign sIf[g + NUM_CH].en    = q.inEn[g];
        assign sIf[g + NUM_CH].value = $signed(q.meas[g]);
        assign sIf[g + NUM_CH].thr   = $signed(q.trpThr[g]);
        assign sIf[g + NUM_CH].dly   = q.trpDly[g];
        assign sIf[g + NUM_CH].tick  = q.tick;
        assign alarmOut[g]           = sIf[g].active;
        assign tripOut[g]            = sIf[g + NUM_CH].active;

        clp_stage uAlarm (
            .clk_sys (clk_sys),
            .resetn  (resetn),
            .bus     (sIf[g])
        );
        clp_stage uTrip (
            .clk_sys (clk_sys),
            .resetn  (resetn),
            .bus     (sIf[g + NUM_CH])
        );
    end

    default clocking cbTop @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    for (genvar g = 0; g < NUM_CH; g++) begin : gChk
        AST_LOW_END: assert property (
            loopValid[g] && loopCurUa[g] == RANGE_LO_UA[q.inRng[g]]
            |=> q.meas[g] == $past(q.inMin[g]))
            else $error("range low end does not give minimum");
        AST_HIGH_END: assert property (
            loopValid[g] && loopCurUa[g] == RANGE_HI_UA[q.inRng[g]]
            |=> q.meas[g] == $past(q.inMax[g]))
            else $error("range top does not give maximum");
        AST_INVERT: assert property (
            loopValid[g] && $signed(q.inMin[g]) > $signed(q.inMax[g])
            |=> $signed(q.meas[g]) <= $signed($past(q.inMin[g]))
                && $signed(q.meas[g]) >= $signed($past(q.inMax[g])))
            else $error("inverted mapping out of window");
        AST_UNIT_SPAN: assert property (
            $signed(q.inMin[g]) >= UNIT_LO[q.inUnit[g]]
            && $signed(q.inMax[g]) <= UNIT_HI[q.inUnit[g]])
            else $error("min or max outside unit span");
        AST_THR_WINDOW: assert property (
            q.almThr[g] == clampS(q.almThr[g], q.inMin[g], q.inMax[g])
            && q.trpThr[g] == clampS(q.trpThr[g], q.inMin[g], q.inMax[g]))
            else $error("threshold outside min..max");
        AST_MEAS_READ: assert property (
            hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && !q.dpWr
            && haddr == {24'h00_0000, IN_BASE + 8'(g * 32)
                         + {3'h0, OFS_IN_MEAS, 2'h0}}
            |=> hrdata == q.meas[g])
            else $error("measurement readback mismatch");
        AST_OUT_FLOOR: assert property (
            q.outRng[g] == RNG_4_20 && q.outMin[g] != q.outMax[g]
            && measPrimary[q.outSel[g]] == q.outMin[g]
            |=> q.outUa[g] == RANGE_LO_UA[RNG_4_20])
            else $error("4-20 output at minimum not at live zero");
        AST_OUT_MAX: assert property (
            q.outMin[g] != q.outMax[g]
            && measPrimary[q.outSel[g]] == q.outMax[g]
            |=> q.outUa[g] == RANGE_HI_UA[$past(q.outRng[g])])
            else $error("output at maximum not at range top");
        AST_OUT_CLAMP: assert property (
            1'b1 |=> q.outUa[g] <= RANGE_HI_UA[$past(q.outRng[g])]
                  && q.outUa[g] >= RANGE_LO_UA[$past(q.outRng[g])])
            else $error("output current beyond range ends");
    end

    COV_INVERTED: cover property (
        loopValid[0] && $signed(q.inMin[0]) > $signed(q.inMax[0]));
    COV_TRIP: cover property ($rose(tripOut[0]));
    COV_OUT_TOP: cover property (
        q.outUa[0] == RANGE_HI_UA[q.outRng[0]] && q.outRng[0] == RNG_4_20);

endmodule

// [clp_pkg.sv]
// shared constants, register map and tables for the current loop block
package clp_pkg;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_PERIOD_NS  = 1000000;
    localparam int MS_TICK_CYC   = MS_PERIOD_NS / CLK_PERIOD_NS;

    // structure
    localparam int NUM_CH  = 4;
    localparam int NUM_SRC = 16;
    localparam int DLY_W   = 16;

    // loop range codes
    localparam logic [1:0] RNG_0_1  = 2'h0;
    localparam logic [1:0] RNG_0_10 = 2'h1;
    localparam logic [1:0] RNG_0_20 = 2'h2;
    localparam logic [1:0] RNG_4_20 = 2'h3;

    // range ends in microamps, indexed by range code
    localparam logic [15:0] RANGE_LO_UA [4] =
        '{16'h0000, 16'h0000, 16'h0000, 16'h0FA0};
    localparam logic [15:0] RANGE_HI_UA [4] =
        '{16'h03E8, 16'h2710, 16'h4E20, 16'h4E20};

    // unit codes 0..10: none, A, V, Hz, W, Var, VA, degC, degF, %, s
    localparam int UNIT_LO [16] = '{-32500, 0, 0, 0, -1410000000,
        -1410000000, 0, -40, -40, 0, 0, -32500, -32500, -32500, -32500,
        -32500};
    localparam int UNIT_HI [16] = '{50000, 100000, 20000, 100, 1410000000,
        1410000000, 1410000000, 400, 752, 150, 300, 50000, 50000, 50000,
        50000, 50000};

    // register map: inputs at 0x00 + ch*0x20, outputs at 0x80 + ch*0x10
    localparam logic [7:0] IN_BASE     = 8'h00;
    localparam logic [7:0] OUT_BASE    = 8'h80;
    localparam logic [7:0] STATUS_ADDR = 8'hC0;
    localparam logic [2:0] OFS_IN_CFG  = 3'h0;
    localparam logic [2:0] OFS_IN_MIN  = 3'h1;
    localparam logic [2:0] OFS_IN_MAX  = 3'h2;
    localparam logic [2:0] OFS_ALM_THR = 3'h3;
    localparam logic [2:0] OFS_ALM_DLY = 3'h4;
    localparam logic [2:0] OFS_TRP_THR = 3'h5;
    localparam logic [2:0] OFS_TRP_DLY = 3'h6;
    localparam logic [2:0] OFS_IN_MEAS = 3'h7;
    localparam logic [1:0] OFS_OUT_CFG = 2'h0;
    localparam logic [1:0] OFS_OUT_MIN = 2'h1;
    localparam logic [1:0] OFS_OUT_MAX = 2'h2;
    localparam logic [1:0] OFS_OUT_UA  = 2'h3;

    // field positions
    localparam int CFG_EN_BIT   = 0;
    localparam int CFG_RNG_LSB  = 1;
    localparam int CFG_UNIT_LSB = 4;
    localparam int OCFG_RNG_LSB = 0;
    localparam int OCFG_SEL_LSB = 4;

    // bus codes and reset value
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;

endpackage

// [clp_stage_if.sv]
// carrier between the main block and one alarm or trip stage
`timescale 1ns/1ns
interface clp_stage_if;
    logic signed [31:0] value;
    logic signed [31:0] thr;
    logic [15:0]        dly;
    logic               en;
    logic               tick;
    logic               active;

    modport stage (input value, input thr, input dly, input en, input tick,
                   output active);
    modport ctrl  (output value, output thr, output dly, output en,
                   output tick, input active);
endinterface

// [clp_stage.sv]
// definite-time threshold stage used for alarm and trip
`timescale 1ns/1ns
module clp_stage
    import clp_pkg::*;
(
    input wire logic    clk_sys,
    input wire logic    resetn,
    clp_stage_if.stage  bus
);

    typedef struct packed {
        logic [DLY_W:0] cnt;
        logic           active;
    } clp_stage_state_t;

    clp_stage_state_t q;
    clp_stage_state_t n;

    // counting past dly guarantees at least dly whole ms of pickup
    always_comb begin
        n = q;
        if (!bus.en || bus.value <= bus.thr) begin
            n.cnt    = '0;
            n.active = 1'b0;
        end else if (q.cnt > {1'b0, bus.dly}) begin
            n.active = 1'b1;
        end else if (bus.tick) begin
            n.cnt = q.cnt + 17'h00001;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign bus.active = q.active;

    default clocking cbStage @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    AST_DISABLED_QUIET: assert property (
        !bus.en |=> !bus.active)
        else $error("stage active while disabled");
    AST_PICKUP_CAUSE: assert property (
        $rose(bus.active) |-> $past(bus.en && bus.value > bus.thr))
        else $error("stage picked up without exceeding threshold");
    AST_DELAY_DONE: assert property (
        $rose(bus.active) |-> $past(q.cnt) > {1'b0, $past(bus.dly)})
        else $error("stage asserted before its delay");
    AST_RESTART: assert property (
        bus.en && bus.value <= bus.thr |=> q.cnt == '0 && !bus.active)
        else $error("stage timer did not restart");
    COV_STAGE_FIRE: cover property ($rose(bus.active));

endmodule

// [clp_loop_source.sv]
// loop transducer model: presents sampled loop currents to the block
`timescale 1ns/1ns
module clp_loop_source
    import clp_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    resetn,
    input  wire logic [NUM_CH-1:0][15:0] curSet,
    output logic [NUM_CH-1:0][15:0]      loopCurUa,
    output logic [NUM_CH-1:0]            loopValid
);
    logic [1:0] phase_q;

    // one sample every four clocks, like a slow converter front end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            phase_q   <= 2'h0;
            loopValid <= '0;
            loopCurUa <= '0;
        end else begin
            phase_q   <= phase_q + 2'h1;
            loopValid <= {NUM_CH{phase_q == 2'h3}};
            // stale between samples: show the inverse, never the last value
            loopCurUa <= (phase_q == 2'h3) ? curSet : ~curSet;
        end
    end
endmodule

// [testbench.sv]
// self-checking bench for the current loop block over its register bus
`timescale 1ns/1ns
module testbench
    import clp_pkg::*;
;
    localparam logic [15:0] HI [4] =
        '{16'h03E8, 16'h2710, 16'h4E20, 16'h4E20};
    logic                     clk_sys = 1'b0;
    logic                     resetn  = 1'b0;
    logic                     hsel    = 1'b0;
    logic [31:0]              haddr   = 32'h0;
    logic [1:0]               htrans  = 2'h0;
    logic                     hwrite  = 1'b0;
    logic [31:0]              hwdata  = 32'h0;
    logic                     hready;
    logic                     hreadyout;
    logic                     hresp;
    logic [31:0]              hrdata;
    logic [NUM_CH-1:0][15:0]  cur     = '0;
    logic [NUM_CH-1:0][15:0]  loopCurUa;
    logic [NUM_CH-1:0]        loopValid;
    logic [NUM_SRC-1:0][31:0] meas    = '0;
    logic [NUM_CH-1:0][15:0]  loopOutUa;
    logic [NUM_CH-1:0]        alarmOut;
    logic [NUM_CH-1:0]        tripOut;
    logic [31:0]              junk;
    int                       failures = 0;
    int                       comparisons = 0;

    always #5 clk_sys = ~clk_sys;
    assign hready = hreadyout;

    clp_current_loop #(.TICK_CYCLES(10)) dut_u (
        .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .loopCurUa(loopCurUa), .loopValid(loopValid),
        .measPrimary(meas), .loopOutUa(loopOutUa), .alarmOut(alarmOut),
        .tripOut(tripOut));

    clp_loop_source src_u (
        .clk_sys(clk_sys), .resetn(resetn), .curSet(cur),
        .loopCurUa(loopCurUa), .loopValid(loopValid));

    task automatic final_report();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // bounded wait for hready at a rising edge
    task automatic wt();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            failures++;
            final_report();
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= w;
        wt();
        htrans <= 2'h0;
        hwdata <= d;
        wt();
        r = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d, junk);
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        chk(v, e);
    endtask

    // new loop current, then let a few samples land
    task automatic sc(input int c, input logic [15:0] v);
        cur[c] <= v;
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic stg(input int n, input logic [31:0] e);
        repeat (n) @(posedge clk_sys);
        chk({24'h0, tripOut, alarmOut}, e);
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        rdc(32'hC0, 32'h0);
        rdc(32'hC4, 32'h0);
        rdc(32'h100, 32'h0);
        wr(32'h04, 32'hFFFFFC18);
        wr(32'h08, 32'h000003E8);
        for (int r = 0; r < 4; r++) begin
            wr(32'h00, 32'h1 | (r << 1));
            sc(0, HI[r]);
            rdc(32'h1C, 32'h000003E8);
        end
        sc(0, 16'h0FA0);
        rdc(32'h1C, 32'hFFFFFC18);
        wr(32'h00, 32'h3);
        sc(0, 16'h1388);
        rdc(32'h1C, 32'h0);
        sc(0, 16'h03E8);
        rdc(32'h1C, 32'hFFFFFCE0);
        wr(32'h20, 32'h3);
        wr(32'h24, 32'h000003E8);
        wr(32'h28, 32'hFFFFFC18);
        sc(1, 16'h2710);
        rdc(32'h3C, 32'hFFFFFC18);
        sc(1, 16'h03E8);
        rdc(32'h3C, 32'h00000320);
        // channel 1 sits above its zero thresholds, so park it disabled
        wr(32'h20, 32'h2);
        wr(32'h40, 32'h90);
        wr(32'h44, 32'hFFFFFFFB);
        wr(32'h48, 32'h000000C8);
        rdc(32'h44, 32'h0);
        rdc(32'h48, 32'h00000096);
        wr(32'h0C, 32'h00001388);
        rdc(32'h0C, 32'h000003E8);
        wr(32'h0C, 32'h000001F4);
        wr(32'h10, 32'h3);
        wr(32'h14, 32'h00000384);
        wr(32'h18, 32'h0);
        sc(0, 16'h1388);
        stg(2, 32'h0);
        sc(0, 16'h2710);
        stg(12, 32'h10);
        sc(0, 16'h1388);
        stg(2, 32'h0);
        sc(0, 16'h2710);
        stg(20, 32'h10);
        stg(20, 32'h11);
        rdc(32'hC0, 32'h11);
        wr(32'h00, 32'h2);
        stg(2, 32'h0);
        rdc(32'hC0, 32'h0);
        meas[2] <= 32'h000003E8;
        wr(32'h84, 32'h0);
        wr(32'h88, 32'h000003E8);
        for (int r = 0; r < 4; r++) begin
            wr(32'h80, 32'h20 | r);
            rdc(32'h8C, {16'h0, HI[r]});
        end
        meas[2] <= 32'h0;
        stg(3, 32'h0);
        chk({16'h0, loopOutUa[0]}, 32'h00000FA0);
        meas[2] <= 32'h000001F4;
        stg(3, 32'h0);
        chk({16'h0, loopOutUa[0]}, 32'h00002EE0);
        meas[2] <= 32'h000007D0;
        rdc(32'h8C, 32'h00004E20);
        meas[2] <= 32'hFFFFFFFB;
        rdc(32'h8C, 32'h00000FA0);
        meas[3] <= 32'h000001F4;
        wr(32'h80, 32'h33);
        rdc(32'h8C, 32'h00002EE0);
        final_report();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        final_report();
    end
endmodule
